// >>> bench/tb_uart_serial_control.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_uart_serial_control;
  import usc_pkg::*;
  logic        CLK_SYS;
  logic        RESETN;
  logic [7:0]  ADDR;
  logic [7:0]  WDATA;
  logic        WR;
  logic        RD;
  logic [7:0]  RDATA;
  logic        RXD_OUT;
  logic        RXD_OE;
  logic        TXD_OUT;
  logic        line;
  logic        rxd_pin;
  logic        nine;
  logic        shift;
  logic [7:0]  v;
  int          len;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  // rows: write address, write data, read address, expected read
  logic [31:0] rows [11] = '{32'h9878_9878, 32'h9880_9880, 32'h8740_9800,
    32'h9800_8740, 32'h8700_9880, 32'h50FF_5000, 32'hA95A_A95A,
    32'hB9FF_B9FF, 32'hC000_C000, 32'h9850_9850, 32'h50FF_C101};
  // shared pin: the block wins while it drives, the far side otherwise
  assign rxd_pin = RXD_OE ? RXD_OUT : line;
  usc_serial_port i_dut (
    .CLK_SYS (CLK_SYS),
    .RESETN  (RESETN),
    .ADDR    (ADDR),
    .WDATA   (WDATA),
    .WR      (WR),
    .RD      (RD),
    .RDATA   (RDATA),
    .RXD_IN  (rxd_pin),
    .RXD_OUT (RXD_OUT),
    .RXD_OE  (RXD_OE),
    .TXD_OUT (TXD_OUT)
  );
  usc_line_model i_line (
    .clk      (CLK_SYS),
    .nine     (nine),
    .shift    (shift),
    .data_in  (rxd_pin),
    .line_in  (TXD_OUT),
    .line_out (line)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    @(negedge CLK_SYS);
    v = RDATA;
  endtask
  task automatic txw(input logic [7:0] d);
    int c0;
    c0 = i_line.count;
    wr(ADDR_DATA, d);
    for (int k = 0; k < 400 && i_line.count == c0; k++) @(posedge CLK_SYS);
  endtask
  task automatic rx(input logic [7:0] b, input logic n9, input logic stop);
    i_line.send(b, n9, stop);
    repeat (4) @(posedge CLK_SYS);
    rd(ADDR_SERIAL_PORT_CONTROL);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    RESETN = 1'b0;
    ADDR   = 8'h00;
    WDATA  = 8'h00;
    WR     = 1'b0;
    RD     = 1'b0;
    nine   = 1'b0;
    shift  = 1'b0;
    repeat (5) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    `CHK("txd idle", 1'b1, TXD_OUT)
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("reset ctrl", 8'h00, v)
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][15:8]);
      `CHK("reg row", rows[i][7:0], v)
    end
    txw(8'hA5);
    `CHK("tx frame", 9'h1A5, i_line.word[8:0])
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("tx flag", 8'h52, v)
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h50);
    rx(8'h3C, 1'b0, 1'b1);
    `CHK("rx flag", 8'h55, v)
    rd(ADDR_DATA);
    `CHK("rx byte", 8'h3C, v)
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h50);
    rx(8'h11, 1'b0, 1'b0);
    wr(ADDR_POWER_CONTROL, 8'h40);
    rx(8'h22, 1'b0, 1'b1);
    `CHK("frame err held", 1'b1, v[7])
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h50);
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("frame err clr", 8'h50, v)
    wr(ADDR_POWER_CONTROL, 8'h00);
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h70);
    rx(8'h33, 1'b0, 1'b1);
    `CHK("addr miss", 8'h70, v)
    rx(8'h5A, 1'b0, 1'b1);
    `CHK("addr hit", 8'h75, v)
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h70);
    rx(8'h5A, 1'b0, 1'b0);
    `CHK("bad stop addr", 1'b0, v[0])
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h40);
    rx(8'h5A, 1'b0, 1'b1);
    `CHK("rx off", 8'h40, v)
    nine = 1'b1;
    wr(ADDR_SERIAL_PORT_CONTROL, 8'hF8);
    txw(8'h5A);
    `CHK("ninth tx", 10'h35A, i_line.word)
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("tx flag 9", 8'hFA, v)
    wr(ADDR_SERIAL_PORT_CONTROL, 8'hF8);
    rx(8'h5A, 1'b0, 1'b1);
    `CHK("data not addr", 8'hF8, v)
    rx(8'h5A, 1'b1, 1'b1);
    `CHK("addr ninth", 8'hFD, v)
    // fixed-rate nine-bit mode, normal and double rate: time data bit 0
    shift = 1'b1;
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h80);
    for (int r = 0; r < 2; r++) begin
      wr(ADDR_POWER_CONTROL, r ? 8'h80 : 8'h00);
      wr(ADDR_DATA, 8'h01);
      @(negedge TXD_OUT);
      @(posedge TXD_OUT);
      len = 0;
      @(negedge CLK_SYS);
      while (TXD_OUT) begin
        len++;
        @(negedge CLK_SYS);
      end
      `CHK("mode2 bit", r ? MODE2_DIV_DBL : MODE2_DIV, len)
      repeat (600) @(posedge CLK_SYS);
    end
    // shift mode send: data on the two-way pin, clock on the other
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h00);
    wr(ADDR_DATA, 8'h96);
    repeat (40) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK("shift oe", 1'b1, RXD_OE)
    repeat (100) @(posedge CLK_SYS);
    `CHK("shift tx", 8'h96, i_line.srx)
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("shift ti", 8'h02, v)
    `CHK("pin free", 1'b0, RXD_OE)
    // shift mode receive with multiprocessor enable set: no filter
    i_line.stx = 8'hC3;
    wr(ADDR_SERIAL_PORT_CONTROL, 8'h30);
    repeat (130) @(posedge CLK_SYS);
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("shift ri", 8'h31, v)
    rd(ADDR_DATA);
    `CHK("shift rx", 8'hC3, v)
    // reset again in mid-run
    @(posedge CLK_SYS);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(ADDR_SERIAL_PORT_CONTROL);
    `CHK("reset again", 8'h00, v)
    `CHK("oe after reset", 1'b0, RXD_OE)
    test_done();
  end
endmodule

// >>> bench/usc_line_model.sv
// far-side serial device: sends frames on the line and captures frames
`timescale 1ns/1ps
module usc_line_model #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic nine,
  input  wire logic shift,
  input  wire logic data_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [9:0] word;
  logic [9:0] sh;
  logic [7:0] srx;
  logic [7:0] stx;
  int         count;
  // the line rests at the mark level between frames
  initial begin
    line_out = 1'b1;
    count    = 0;
    stx      = 8'hFF;
  end
  // last slot is a full idle bit in eight-bit frames; nine-bit frames end on the stop bit
  task automatic send(input logic [7:0] b, input logic n9, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, n9, b, 1'b0} : {1'b1, stop, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
  // sample mid-bit, lsb first, stop bit kept at the top
  always begin
    @(negedge line_in);
    if (!shift) begin
      sh = '0;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (BIT) @(posedge clk);
        sh[i] = line_in;
      end
      word = sh;
      count++;
    end
  end
  // shift mode: take data on the rising shift clock, offer on the falling
  always @(posedge line_in) begin
    if (shift) begin
      srx = {data_in, srx[7:1]};
    end
  end
  always @(negedge line_in) begin
    if (shift) begin
      line_out <= stx[0];
      stx = {1'b1, stx[7:1]};
    end
  end
endmodule

// >>> rtl/usc_fifo.sv
// transmit buffer: flop memory with valid/ready on both sides
`timescale 1ns/1ps
module usc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  usc_stream_if.snk   wr_side,
  usc_stream_if.src   rd_side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      wp_next;
  logic [AW:0]      rp_reg;
  logic [AW:0]      rp_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full  = (wp_reg[AW] != rp_reg[AW]) &&
                 (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty = (wp_reg == rp_reg);
  assign push  = wr_side.valid && !full;
  assign pop   = rd_side.ready && !empty;
  assign wr_side.ready = !full;
  assign rd_side.valid = !empty;
  assign rd_side.data  = mem_reg[rp_reg[AW-1:0]];

  always_comb begin
    mem_next = mem_reg;
    if (push) begin
      mem_next[wp_reg[AW-1:0]] = wr_side.data;
    end
    wp_next = wp_reg + {{AW{1'b0}}, push};
    rp_next = rp_reg + {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // storage needs no reset: empty flag guards stale words
  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
  end
endmodule

// >>> rtl/usc_pkg.sv
// constants and types for the serial port control block
package usc_pkg;

  localparam logic [7:0] ADDR_SERIAL_PORT_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA                = 8'h99;
  localparam logic [7:0] ADDR_POWER_CONTROL       = 8'h87;
  localparam logic [7:0] ADDR_GIVEN               = 8'hA9;
  localparam logic [7:0] ADDR_MASK                = 8'hB9;
  localparam logic [7:0] ADDR_BAUD                = 8'hC0;
  localparam logic [7:0] ADDR_STATUS              = 8'hC1;

  localparam int BIT_MODE0 = 7;
  localparam int BIT_MODE1 = 6;
  localparam int BIT_MP    = 5;
  localparam int BIT_REN   = 4;
  localparam int BIT_TB8   = 3;
  localparam int BIT_RB8   = 2;
  localparam int BIT_TI    = 1;
  localparam int BIT_RI    = 0;
  localparam int BIT_DBL   = 7;
  localparam int BIT_FES   = 6;

  localparam logic [7:0] RST_SERIAL_PORT_CONTROL  = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_ADDR  = 8'h00;
  localparam logic [7:0] RST_BAUD  = 8'h00;

  localparam int         SHIFT_DIV     = 12;
  localparam int         OVERSAMPLE    = 16;
  localparam int         MODE2_DIV     = 64;
  localparam int         MODE2_DIV_DBL = 32;
  localparam logic [3:0] SHIFT_LAST    = 4'(SHIFT_DIV - 1);
  localparam logic [3:0] SHIFT_HALF    = 4'(SHIFT_DIV / 2);
  localparam logic [3:0] SUB_LAST      = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] HALF_LAST     = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [7:0] MODE2_LIM     = 8'(MODE2_DIV / OVERSAMPLE - 1);
  localparam logic [7:0] MODE2_LIM_DBL = 8'(MODE2_DIV_DBL / OVERSAMPLE - 1);
  localparam logic [3:0] LAST_SHIFT    = 4'h7;
  localparam logic [3:0] LAST_UART8    = 4'h9;
  localparam logic [3:0] LAST_UART9    = 4'hA;

  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_UART8  = 2'b01,
    MODE_UART9F = 2'b10,
    MODE_UART9V = 2'b11
  } usc_mode_t;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } usc_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11
  } usc_rx_state_t;

endpackage

// >>> rtl/usc_serial_port.sv
// serial port control: modes, flags, address filter, shifters
`timescale 1ns/1ps
module usc_serial_port
  import usc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RESETN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       RXD_IN,
  output logic            RXD_OUT,
  output logic            RXD_OE,
  output logic            TXD_OUT
);

  ////////////////////////////////////////////////////////////////////////
  logic          mode0_reg, mode0_next, fe_reg, fe_next;
  logic          fes_reg, fes_next, dbl_reg, dbl_next;
  logic [6:0]    ctl_reg, ctl_next;
  logic [7:0]    given_reg, given_next, mask_reg, mask_next;
  logic [7:0]    baud_reg, baud_next, rxbuf_reg, rxbuf_next;
  logic [7:0]    rdata_reg, rdata_next;
  logic [3:0]    sh_cnt_reg, sh_cnt_next;
  logic [7:0]    os_cnt_reg, os_cnt_next, os_lim;
  usc_tx_state_t tx_state_reg, tx_state_next;
  logic [10:0]   tx_sh_reg, tx_sh_next;
  logic [3:0]    tx_bit_reg, tx_bit_next, tx_sub_reg, tx_sub_next;
  usc_rx_state_t rx_state_reg, rx_state_next;
  logic [9:0]    rx_sh_reg, rx_sh_next, rx_sample;
  logic [3:0]    rx_bit_reg, rx_bit_next, rx_sub_reg, rx_sub_next;
  logic          txd_reg, txd_next, rxo_reg, rxo_next, oe_reg, oe_next;
  usc_mode_t     mode;
  logic          is_shift, is_uart8, mp, ren, ri;
  logic          tick12, tick16, tick, sc_wr, rxd;
  logic [3:0]    tx_last, rx_last;
  logic          tx_load, tx_bit_end, ti_set;
  logic          rx_done, rx_accept, fe_set, filt_ok, addr_match;
  logic [7:0]    rx_byte, bcast;
  logic          rx_ninth, rx_stop;

  usc_stream_if #(.WIDTH(8)) fill_if ();
  usc_stream_if #(.WIDTH(8)) drain_if ();

  usc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk     (CLK_SYS),
    .rst_n   (RESETN),
    .wr_side (fill_if),
    .rd_side (drain_if)
  );

  usc_sync3 #(
    .RESET_VAL (1'b1)
  ) u_rx_sync (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .d     (RXD_IN),
    .q     (rxd)
  );

  ////////////////////////////////////////////////////////////////////////
  assign mode     = usc_mode_t'({mode0_reg, ctl_reg[BIT_MODE1]});
  assign is_shift = (mode == MODE_SHIFT);
  assign is_uart8 = (mode == MODE_UART8);
  assign mp       = ctl_reg[BIT_MP];
  assign ren      = ctl_reg[BIT_REN];
  assign ri       = ctl_reg[BIT_RI];
  assign sc_wr    = WR && (ADDR == ADDR_SERIAL_PORT_CONTROL);

  // mode 2 fixed rate, modes 1 and 3 from the software divider
  assign os_lim = (mode == MODE_UART9F) ?
                  (dbl_reg ? MODE2_LIM_DBL : MODE2_LIM) : baud_reg;
  assign tick12 = (sh_cnt_reg == SHIFT_LAST);
  assign tick16 = (os_cnt_reg >= os_lim);
  assign tick   = is_shift ? tick12 : tick16;

  always_comb begin
    sh_cnt_next = tick12 ? 4'h0 : sh_cnt_reg + 4'h1;
    os_cnt_next = tick16 ? 8'h00 : os_cnt_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  assign tx_last = is_shift ? LAST_SHIFT :
                   (is_uart8 ? LAST_UART8 : LAST_UART9);
  assign fill_if.valid  = WR && (ADDR == ADDR_DATA);
  assign fill_if.data   = WDATA;
  // shift mode is half duplex: no send while a receive shifts; a send
  // there starts on a slot edge so the first bit gets a whole clock
  assign drain_if.ready = (tx_state_reg == TX_IDLE) &&
                          !(is_shift && (rx_state_reg != RX_IDLE ||
                                         !tick12));
  assign tx_load    = drain_if.valid && drain_if.ready;
  assign tx_bit_end = tick && (is_shift || tx_sub_reg == SUB_LAST);

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_sh_next    = tx_sh_reg;
    tx_bit_next   = tx_bit_reg;
    tx_sub_next   = tx_sub_reg;
    ti_set        = 1'b0;
    case (tx_state_reg)
      TX_IDLE: begin
        if (tx_load) begin
          tx_state_next = TX_SHIFT;
          tx_bit_next   = 4'h0;
          tx_sub_next   = 4'h0;
          if (is_shift) begin
            tx_sh_next = {3'b111, drain_if.data};
          end else if (is_uart8) begin
            tx_sh_next = {2'b11, drain_if.data, 1'b0};
          end else begin
            tx_sh_next = {1'b1, ctl_reg[BIT_TB8], drain_if.data, 1'b0};
          end
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          tx_sub_next = tx_sub_reg + 4'h1;
        end
        if (tx_bit_end) begin
          tx_bit_next = tx_bit_reg + 4'h1;
          tx_sh_next  = {1'b1, tx_sh_reg[10:1]};
          if (tx_bit_reg == (is_shift ? tx_last : tx_last - 4'h1)) begin
            ti_set = 1'b1;
          end
          if (tx_bit_reg == tx_last) begin
            tx_state_next = TX_IDLE;
          end
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  assign rx_last   = is_shift ? LAST_SHIFT : tx_last - 4'h1;
  assign rx_sample = {rxd, rx_sh_reg[9:1]};
  assign rx_byte   = is_shift ? rx_sample[9:2] :
                     (is_uart8 ? rx_sample[8:1] : rx_sample[7:0]);
  assign rx_ninth  = rx_sample[8];
  assign rx_stop   = rx_sample[9];
  assign bcast     = given_reg | mask_reg;
  assign addr_match = (((rx_byte ^ given_reg) & mask_reg) == 8'h00) ||
                      ((rx_byte & bcast) == bcast);
  assign filt_ok   = is_shift || !mp ||
                     (is_uart8 ? (rx_stop && addr_match) :
                                 (rx_ninth && addr_match));
  assign rx_accept = rx_done && !ri && filt_ok;
  assign fe_set    = rx_done && !is_shift && !rx_stop;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_sh_next    = rx_sh_reg;
    rx_bit_next   = rx_bit_reg;
    rx_sub_next   = rx_sub_reg;
    rx_done       = 1'b0;
    if (!ren) begin
      rx_state_next = RX_IDLE;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_sub_next = 4'h0;
          rx_bit_next = 4'h0;
          if (is_shift) begin
            if (tick && !ri && tx_state_reg == TX_IDLE &&
                !drain_if.valid) begin
              rx_state_next = RX_DATA;
            end
          end else if (!rxd) begin
            rx_state_next = RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_sub_next = rx_sub_reg + 4'h1;
            // a start bit gone by mid-bit was a glitch
            if (rx_sub_reg == HALF_LAST) begin
              rx_sub_next   = 4'h0;
              rx_state_next = rxd ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_sub_next = rx_sub_reg + 4'h1;
          end
          if (tick && (is_shift || rx_sub_reg == SUB_LAST)) begin
            rx_sh_next  = rx_sample;
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == rx_last) begin
              rx_state_next = RX_IDLE;
              rx_done       = 1'b1;
            end
          end
        end
        default: rx_state_next = RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode0_next = mode0_reg;
    fe_next    = fe_reg;
    ctl_next   = ctl_reg;
    fes_next   = fes_reg;
    dbl_next   = dbl_reg;
    given_next = given_reg;
    mask_next  = mask_reg;
    baud_next  = baud_reg;
    rxbuf_next = rxbuf_reg;
    rdata_next = 8'h00;
    if (sc_wr) begin
      if (fes_reg) begin
        fe_next = WDATA[BIT_MODE0];
      end else begin
        mode0_next = WDATA[BIT_MODE0];
      end
      ctl_next = WDATA[6:0];
    end
    if (WR && ADDR == ADDR_POWER_CONTROL) begin
      dbl_next = WDATA[BIT_DBL];
      fes_next = WDATA[BIT_FES];
    end
    if (WR && ADDR == ADDR_GIVEN) begin
      given_next = WDATA;
    end
    if (WR && ADDR == ADDR_MASK) begin
      mask_next = WDATA;
    end
    if (WR && ADDR == ADDR_BAUD) begin
      baud_next = WDATA;
    end
    // hardware sets come last so they win over a same-cycle write
    if (fe_set) begin
      fe_next = 1'b1;
    end
    if (ti_set) begin
      ctl_next[BIT_TI] = 1'b1;
    end
    if (rx_accept) begin
      ctl_next[BIT_RI] = 1'b1;
      rxbuf_next = rx_byte;
      if (!is_shift) begin
        ctl_next[BIT_RB8] = is_uart8 ? rx_stop : rx_ninth;
      end
    end
    if (RD) begin
      case (ADDR)
        ADDR_SERIAL_PORT_CONTROL:
          rdata_next = {fes_reg ? fe_reg : mode0_reg, ctl_reg};
        ADDR_DATA:          rdata_next = rxbuf_reg;
        ADDR_POWER_CONTROL: rdata_next = {dbl_reg, fes_reg, 6'h00};
        ADDR_GIVEN:         rdata_next = given_reg;
        ADDR_MASK:          rdata_next = mask_reg;
        ADDR_BAUD:          rdata_next = baud_reg;
        ADDR_STATUS:        rdata_next = {5'h00, rx_state_reg != RX_IDLE,
                                          tx_state_reg != TX_IDLE,
                                          fill_if.ready};
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift mode: data on the two-way pin, shift clock on the other
  always_comb begin
    txd_next = 1'b1;
    rxo_next = 1'b1;
    oe_next  = 1'b0;
    if (tx_state_reg == TX_SHIFT && !is_shift) begin
      txd_next = tx_sh_reg[0];
    end
    if (is_shift && (tx_state_reg == TX_SHIFT ||
                     rx_state_reg == RX_DATA)) begin
      txd_next = (sh_cnt_reg >= SHIFT_HALF);
    end
    if (is_shift && tx_state_reg == TX_SHIFT) begin
      rxo_next = tx_sh_reg[0];
      oe_next  = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mode0_reg    <= RST_SERIAL_PORT_CONTROL[BIT_MODE0];
      fe_reg       <= RST_SERIAL_PORT_CONTROL[BIT_MODE0];
      ctl_reg      <= RST_SERIAL_PORT_CONTROL[6:0];
      fes_reg      <= RST_POWER[BIT_FES];
      dbl_reg      <= RST_POWER[BIT_DBL];
      given_reg    <= RST_ADDR;
      mask_reg     <= RST_ADDR;
      baud_reg     <= RST_BAUD;
      rxbuf_reg    <= 8'h00;
      rdata_reg    <= 8'h00;
      sh_cnt_reg   <= 4'h0;
      os_cnt_reg   <= 8'h00;
      tx_state_reg <= TX_IDLE;
      tx_sh_reg    <= 11'h7FF;
      tx_bit_reg   <= 4'h0;
      tx_sub_reg   <= 4'h0;
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 10'h000;
      rx_bit_reg   <= 4'h0;
      rx_sub_reg   <= 4'h0;
      txd_reg      <= 1'b1;
      rxo_reg      <= 1'b1;
      oe_reg       <= 1'b0;
    end else begin
      mode0_reg    <= mode0_next;
      fe_reg       <= fe_next;
      ctl_reg      <= ctl_next;
      fes_reg      <= fes_next;
      dbl_reg      <= dbl_next;
      given_reg    <= given_next;
      mask_reg     <= mask_next;
      baud_reg     <= baud_next;
      rxbuf_reg    <= rxbuf_next;
      rdata_reg    <= rdata_next;
      sh_cnt_reg   <= sh_cnt_next;
      os_cnt_reg   <= os_cnt_next;
      tx_state_reg <= tx_state_next;
      tx_sh_reg    <= tx_sh_next;
      tx_bit_reg   <= tx_bit_next;
      tx_sub_reg   <= tx_sub_next;
      rx_state_reg <= rx_state_next;
      rx_sh_reg    <= rx_sh_next;
      rx_bit_reg   <= rx_bit_next;
      rx_sub_reg   <= rx_sub_next;
      txd_reg      <= txd_next;
      rxo_reg      <= rxo_next;
      oe_reg       <= oe_next;
    end
  end

  assign RDATA   = rdata_reg;
  assign TXD_OUT = txd_reg;
  assign RXD_OUT = rxo_reg;
  assign RXD_OE  = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  frame_shape_a: assert property (
    tx_load && mode0_reg |=> !tx_sh_reg[0] && tx_sh_reg[10] &&
      tx_sh_reg[9] == $past(ctl_reg[BIT_TB8]))
    else $error("nine-bit frame loaded wrongly");
  fe_view_a: assert property (
    RD && ADDR == ADDR_SERIAL_PORT_CONTROL |=>
      RDATA[7] == ($past(fes_reg) ? $past(fe_reg) : $past(mode0_reg)))
    else $error("bit 7 read shows wrong function");
  fe_sticky_a: assert property (
    fe_reg && !(sc_wr && fes_reg) |=> fe_reg)
    else $error("framing flag dropped without write");
  fe_set_a: assert property (
    rx_done && !is_shift && !rx_stop |=> fe_reg)
    else $error("bad stop bit did not flag");
  nine_filter_a: assert property (
    rx_done && mode0_reg && mp && !(rx_ninth && addr_match) &&
      !ri && !sc_wr |=> !ri)
    else $error("nine-bit filter let frame through");
  eight_stop_a: assert property (
    rx_done && is_uart8 && mp && !(rx_stop && addr_match) &&
      !ri && !sc_wr |=> !ri)
    else $error("eight-bit filter let frame through");
  shift_nofilt_a: assert property (
    rx_done && is_shift && !ri |=> ri && rxbuf_reg == $past(rx_byte))
    else $error("shift mode byte not taken");
  ren_stop_a: assert property (
    !ren |=> rx_state_reg == RX_IDLE ##1 rx_state_reg == RX_IDLE
      or ren)
    else $error("reception ran with enable clear");
  rb8_take_a: assert property (
    rx_accept && mode0_reg |=> ctl_reg[BIT_RB8] == $past(rx_ninth))
    else $error("ninth bit not captured");
  ti_win_a: assert property (
    ti_set |=> ctl_reg[BIT_TI])
    else $error("transmit flag lost");
  ri_hold_a: assert property (
    ri && !sc_wr |=> ri)
    else $error("receive flag cleared by hardware");

  tx_done_c: cover property (ti_set && !is_shift);
  rx_take_c: cover property (rx_accept && mp && mode0_reg);
  fe_hit_c:  cover property (fe_set && fes_reg);
  shift_c:   cover property (rx_accept && is_shift);
endmodule

// >>> rtl/usc_stream_if.sv
// valid/ready stream between the port logic and its buffer
`timescale 1ns/1ps
interface usc_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/usc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module usc_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [2:0] ff_reg;
  logic [2:0] ff_next;
  logic       q_reg;
  logic       q_next;

  // output moves only once stages two and three agree
  always_comb begin
    ff_next = {ff_reg[1:0], d};
    q_next  = (ff_reg[1] == ff_reg[2]) ? ff_reg[2] : q_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_reg <= {3{RESET_VAL}};
      q_reg  <= RESET_VAL;
    end else begin
      ff_reg <= ff_next;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule
